// file: src/keypad_wake_unit.sv
/*
 * Keypad wake unit: up to eight key inputs with per-pin enable and
 * polarity, edge or edge-and-level detection, one event flag, interrupt
 * request and low-power wake request, reached over an AHB-Lite slave.
 * Assumes one clock, synchronous active-low reset, single word transfers
 * and pins that may be asynchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "keypad_wake_defs.svh"

// Overview of operation
// - Eight pins, each with its own enable
// - Per pin: falling or rising; one mode bit adds level for all pins
// - One shared request, gated by interrupt enable
// - Keeps running in wait; event wakes processor
// - Stop3 detection works without the bus clock
// - Enabled pin event wakes from stop3 if enabled
// - Unchanged behaviour during background debug
// - Status/control, pin enable, polarity registers
// - Several instances, each with indexed registers
// - Sampled edges; rearm after all deasserted
// - Event sets flag; ack write clears it
// - Level mode: ack fails while pin asserted
// - Mode bit and polarity bit encodings
module keypad_wake_unit
	import keypad_wake_pkg::*;
#(
	parameter int PINS = 8,
	parameter int INSTANCE_INDEX = 0,
	parameter logic [15:0] INSTANCE_STRIDE = 16'h0010
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	input wire logic [PINS-1:0] KEY_INPUT_PINS,
	input wire logic WAIT_MODE,
	input wire logic STOP3_MODE,
	output logic KEY_IRQ,
	output logic WAKE_REQ,
	output logic SYS_IRQ
);

	// Register offset for this instance
	localparam logic [15:0] INST_OFFSET =
		16'(INSTANCE_INDEX) * INSTANCE_STRIDE;

	// Decode one register word for this instance
	function automatic logic reg_hit(input logic [31:0] addr,
		input logic [15:0] index);
		logic [15:0] full;
		full = index + INST_OFFSET;
		reg_hit = (addr[1:0] == 2'h0) && (addr[31:18] == 14'h0000) &&
			(addr[17:2] == full);
	endfunction

	// Synchronised pin samples
	logic [PINS-1:0] pin_now;
	logic [PINS-1:0] pin_prev;

	// Software controls
	logic key_irq_enable;
	logic next_key_irq_enable;
	logic detect_mode_select;
	logic next_detect_mode_select;
	logic [PINS-1:0] pin_detect_enable;
	logic [PINS-1:0] next_pin_detect_enable;
	logic [PINS-1:0] pin_polarity_select;
	logic [PINS-1:0] next_pin_polarity_select;

	// Detection state
	logic key_event_flag;
	logic next_key_event_flag;
	logic armed;
	logic next_armed;

	// Sticky status and mask
	logic [`KW_EV_WIDTH-1:0] irq_status;
	logic [`KW_EV_WIDTH-1:0] next_irq_status;
	logic [`KW_EV_WIDTH-1:0] irq_mask;
	logic [`KW_EV_WIDTH-1:0] next_irq_mask;

	// Bus slave state
	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [31:0] bus_addr;
	logic [31:0] next_bus_addr;
	logic [31:0] next_hrdata;

	// Per-pin decode
	logic [PINS-1:0] asserted_now;
	logic [PINS-1:0] asserted_prev;
	logic [PINS-1:0] asserted_raw;
	logic any_asserted;
	logic edge_seen;
	logic level_seen;
	logic key_event;

	// Bus decode
	logic addr_phase;
	logic wr_now;
	logic wr_sc;
	logic ack_write;
	logic ack_refused;
	logic [31:0] read_value;

	// Pins are synchronised before edge and level comparison; stop3 wake compares raw pins
	key_pin_sync #(
		.WIDTH(PINS)
	) u_sync (
		.clk(SYS_CLK),
		.reset_n(RESET_N),
		.pins(KEY_INPUT_PINS),
		.synced(pin_now),
		.previous(pin_prev)
	);

	// Asserted level per pin from its polarity bit
	generate
		for (genvar i = 0; i < PINS; i++) begin : g_pin
			// Polarity 1 means high or rising, 0 means low or falling
			assign asserted_now[i] = pin_detect_enable[i] &
				(pin_now[i] ~^ pin_polarity_select[i]);
			assign asserted_prev[i] = pin_detect_enable[i] &
				(pin_prev[i] ~^ pin_polarity_select[i]);
			assign asserted_raw[i] = pin_detect_enable[i] &
				(KEY_INPUT_PINS[i] ~^ pin_polarity_select[i]);
		end
	endgenerate

	// Edge and level detection
	always_comb begin
		any_asserted = |asserted_now;
		// Deasserted one cycle, asserted the next, while armed
		edge_seen = armed & |(asserted_now & ~asserted_prev);
		// Level counts only in edge-and-level mode
		level_seen = detect_mode_select & any_asserted;
		key_event = edge_seen | level_seen;
	end

	// Bus address phase and write decode
	always_comb begin
		addr_phase = HSEL & HREADY & HTRANS[`KW_HTRANS_NONSEQ_BIT];
		wr_now = (bus_state == BUS_WRITE);
		wr_sc = wr_now & reg_hit(bus_addr, `KW_SC_INDEX);
		ack_write = wr_sc & HWDATA[`KW_SC_ACK_BIT];
		// Level mode keeps the flag while any enabled pin is asserted
		ack_refused = ack_write & detect_mode_select & any_asserted;
	end

	// Next values of the software controls
	always_comb begin
		next_key_irq_enable = key_irq_enable;
		next_detect_mode_select = detect_mode_select;
		next_pin_detect_enable = pin_detect_enable;
		next_pin_polarity_select = pin_polarity_select;
		next_irq_mask = irq_mask;
		if (wr_sc) begin
			next_key_irq_enable = HWDATA[`KW_SC_IRQ_EN_BIT];
			next_detect_mode_select = HWDATA[`KW_SC_MODE_BIT];
		end
		if (wr_now && reg_hit(bus_addr, `KW_PE_INDEX)) begin
			next_pin_detect_enable = HWDATA[PINS-1:0];
		end
		if (wr_now && reg_hit(bus_addr, `KW_ES_INDEX)) begin
			next_pin_polarity_select = HWDATA[PINS-1:0];
		end
		if (wr_now && reg_hit(bus_addr, `KW_IRQ_MASK_INDEX)) begin
			next_irq_mask = HWDATA[`KW_EV_WIDTH-1:0];
		end
	end

	// Software control registers
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			key_irq_enable <= 1'b0;
			detect_mode_select <= 1'b0;
			pin_detect_enable <= `KW_PINS_RESET;
			pin_polarity_select <= `KW_PINS_RESET;
			irq_mask <= `KW_EV_RESET;
		end else begin
			key_irq_enable <= next_key_irq_enable;
			detect_mode_select <= next_detect_mode_select;
			pin_detect_enable <= next_pin_detect_enable;
			pin_polarity_select <= next_pin_polarity_select;
			irq_mask <= next_irq_mask;
		end
	end

	// Next values of flag, arming and sticky status
	always_comb begin
		// Rearm only once every enabled pin is deasserted
		if (!any_asserted) begin
			next_armed = 1'b1;
		end else if (edge_seen) begin
			next_armed = 1'b0;
		end else begin
			next_armed = armed;
		end
		// A new event wins over an acknowledge in the same cycle
		if (key_event) begin
			next_key_event_flag = 1'b1;
		end else if (ack_write && !ack_refused) begin
			next_key_event_flag = 1'b0;
		end else begin
			next_key_event_flag = key_event_flag;
		end
		next_irq_status = irq_status;
		if (wr_now && reg_hit(bus_addr, `KW_IRQ_STATUS_INDEX)) begin
			next_irq_status = irq_status & ~HWDATA[`KW_EV_WIDTH-1:0];
		end
		// Set after clear so new events are never lost
		if (key_event) begin
			next_irq_status[`KW_EV_KEY_BIT] = 1'b1;
		end
		if (ack_refused) begin
			next_irq_status[`KW_EV_REFUSED_BIT] = 1'b1;
		end
	end

	// Flag, arming and status registers
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			key_event_flag <= 1'b0;
			armed <= 1'b0;
			irq_status <= `KW_EV_RESET;
		end else begin
			key_event_flag <= next_key_event_flag;
			armed <= next_armed;
			irq_status <= next_irq_status;
		end
	end

	// Register read multiplexer; unmapped words read zero
	always_comb begin
		read_value = 32'h0000_0000;
		if (reg_hit(bus_addr, `KW_SC_INDEX)) begin
			// Flag is read only; acknowledge always reads zero
			read_value[`KW_SC_FLAG_BIT] = key_event_flag;
			read_value[`KW_SC_IRQ_EN_BIT] = key_irq_enable;
			read_value[`KW_SC_MODE_BIT] = detect_mode_select;
		end else if (reg_hit(bus_addr, `KW_PE_INDEX)) begin
			read_value[PINS-1:0] = pin_detect_enable;
		end else if (reg_hit(bus_addr, `KW_ES_INDEX)) begin
			read_value[PINS-1:0] = pin_polarity_select;
		end else if (reg_hit(bus_addr, `KW_IRQ_STATUS_INDEX)) begin
			read_value[`KW_EV_WIDTH-1:0] = irq_status;
		end else if (reg_hit(bus_addr, `KW_IRQ_MASK_INDEX)) begin
			read_value[`KW_EV_WIDTH-1:0] = irq_mask;
		end
	end

	// Bus slave sequencing; reads take one wait state
	always_comb begin
		next_bus_state = bus_state;
		next_bus_addr = bus_addr;
		next_hrdata = HRDATA;
		case (bus_state)
			BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
				if (addr_phase) begin
					next_bus_addr = HADDR;
					next_bus_state = HWRITE ? BUS_WRITE : BUS_RD_WAIT;
				end else begin
					next_bus_state = BUS_IDLE;
				end
			end
			BUS_RD_WAIT: begin
				// Capture after any previous write has landed
				next_hrdata = read_value;
				next_bus_state = BUS_RD_DONE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// Bus slave registers
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			bus_state <= BUS_IDLE;
			bus_addr <= 32'h0000_0000;
			HRDATA <= 32'h0000_0000;
		end else begin
			bus_state <= next_bus_state;
			bus_addr <= next_bus_addr;
			HRDATA <= next_hrdata;
		end
	end

	// Bus handshake and response
	assign HREADYOUT = (bus_state != BUS_RD_WAIT);
	assign HRESP = `KW_HRESP_OKAY;

	// Interrupt request keeps running in wait and debug alike
	assign KEY_IRQ = key_event_flag & key_irq_enable;

	// Sticky status gated by mask
	assign SYS_IRQ = |(irq_status & irq_mask);

	// Wake: flagged request in wait, flag or raw pin level in stop3
	assign WAKE_REQ = key_irq_enable & ((WAIT_MODE & key_event_flag) |
		(STOP3_MODE & (key_event_flag | |asserted_raw)));

endmodule
`default_nettype wire

// file: src/keypad_wake_defs.svh
/*
 * Register indexes, field positions, reset values and bus constants
 * of the keypad wake unit.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef KEYPAD_WAKE_DEFS_SVH
`define KEYPAD_WAKE_DEFS_SVH

// Register indexes; byte address is four times the index
`define KW_SC_INDEX 16'h003c
`define KW_PE_INDEX 16'h307c
`define KW_ES_INDEX 16'h307d
`define KW_IRQ_STATUS_INDEX 16'h3080
`define KW_IRQ_MASK_INDEX 16'h3081

// Status and control field positions
`define KW_SC_MODE_BIT 0
`define KW_SC_IRQ_EN_BIT 1
`define KW_SC_ACK_BIT 2
`define KW_SC_FLAG_BIT 3

// Sticky event status field positions
`define KW_EV_KEY_BIT 0
`define KW_EV_REFUSED_BIT 1
`define KW_EV_WIDTH 2

// Reset values
`define KW_PINS_RESET 8'h00
`define KW_EV_RESET 2'h0

// Bus constants
`define KW_HTRANS_NONSEQ_BIT 1
`define KW_HRESP_OKAY 1'b0

`endif

// file: src/keypad_wake_pkg.sv
/*
 * Types shared by the keypad wake unit.
 * Assumes nothing beyond the constants header.
 */
package keypad_wake_pkg;

	// Register bus slave states
	typedef enum logic [3:0] {
		BUS_IDLE = 4'b0001,
		BUS_WRITE = 4'b0010,
		BUS_RD_WAIT = 4'b0100,
		BUS_RD_DONE = 4'b1000
	} bus_state_t;

endpackage

// file: src/key_pin_sync.sv
/*
 * Two-stage synchroniser for the key input pins plus one history stage.
 * Assumes pins may change at any time relative to the clock.
 */
`timescale 1ns/100ps
`default_nettype none

module key_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] synced,
	output logic [WIDTH-1:0] previous
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_synced;
	logic [WIDTH-1:0] next_previous;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = pins;
		next_synced = meta;
		next_previous = synced;
	end

	// Synchroniser and history registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta <= '0;
			synced <= '0;
			previous <= '0;
		end else begin
			meta <= next_meta;
			synced <= next_synced;
			previous <= next_previous;
		end
	end

endmodule
`default_nettype wire

// file: testbench/keypad_wake_unit_properties.sv
/*
 * Checker for the keypad wake unit: bus timing, wake and interrupt outputs.
 * Assumes it is bound to the unit's top ports with HREADY tied to HREADYOUT.
 */
`timescale 1ns/100ps
`default_nettype none

module keypad_wake_unit_checker (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic [31:0] HRDATA,
	input wire logic WAIT_MODE,
	input wire logic STOP3_MODE,
	input wire logic KEY_IRQ,
	input wire logic WAKE_REQ,
	input wire logic SYS_IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	// Bus phases
	sequence s_rd_take; HSEL && HREADY && HTRANS[1] && !HWRITE; endsequence
	sequence s_wr_take; HSEL && HREADY && HTRANS[1] && HWRITE; endsequence
	sequence s_rd_wait; !HREADYOUT ##1 HREADYOUT; endsequence

	property p_read_wait; s_rd_take |=> s_rd_wait; endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait");
	property p_write_ready; s_wr_take |=> HREADYOUT; endproperty
	a_write_ready: assert property (p_write_ready) else $error("wr wait");
	property p_okay; HRESP == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_wait_wake; WAIT_MODE && !STOP3_MODE |-> WAKE_REQ == KEY_IRQ;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait wake");
	property p_stop_wake; STOP3_MODE && KEY_IRQ |-> WAKE_REQ; endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop wake");
	property p_run_no_wake; !WAIT_MODE && !STOP3_MODE |-> !WAKE_REQ; endproperty
	a_run_no_wake: assert property (p_run_no_wake) else $error("wake");
	// Request only drops after a register write lands
	property p_irq_clear; $fell(KEY_IRQ) |-> $past(HSEL && HREADY && HTRANS[1]
		&& HWRITE, 2); endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq drop");
	property p_reset_clear; disable iff (1'b0) !RESET_N |=> !KEY_IRQ && !SYS_IRQ
		&& HRDATA == 32'h0; endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset");
endmodule

bind keypad_wake_unit keypad_wake_unit_checker keypad_wake_unit_checker_inst (
	.SYS_CLK, .RESET_N, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP,
	.HRDATA, .WAIT_MODE, .STOP3_MODE, .KEY_IRQ, .WAKE_REQ, .SYS_IRQ);

`default_nettype wire

// file: testbench/key_switch_model.sv
/*
 * Key switch model: pins follow requested levels after a settling delay.
 * Assumes the bench changes the levels at clock edges.
 */
`timescale 1ns/100ps
`default_nettype none

module key_switch_model (
	input wire logic [7:0] level,
	output logic [7:0] pins
);
	// Switches settle off the clock edge, a fixed 37 ns after each level change
	initial pins = 8'h00;
	always @(level) pins <= #37 level;
endmodule

`default_nettype wire

// file: testbench/keypad_wake_unit_bench.sv
/*
 * Self-checking bench of the keypad wake unit with a bus master.
 * Assumes the unit, its bound checker and the key switch model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "keypad_wake_defs.svh"

module keypad_wake_unit_bench;
	logic sys_clk = 1'b0;
	logic reset_n, hsel, hwrite, hready, hreadyout, hresp, wait_mode;
	logic stop3_mode, key_irq, wake_req, sys_irq;
	logic [1:0] htrans;
	logic [2:0] hsize, obs;
	logic [31:0] haddr, hwdata, hrdata, q, rnd;
	logic [7:0] lvl, pins, es;
	int fails = 0;
	int checks_done = 0;
	localparam logic [31:0] ad_sc = `KW_SC_INDEX * 4;
	localparam logic [31:0] ad_pe = `KW_PE_INDEX * 4;
	localparam logic [31:0] ad_es = `KW_ES_INDEX * 4;
	localparam logic [31:0] ad_st = `KW_IRQ_STATUS_INDEX * 4;
	localparam logic [31:0] ad_mk = `KW_IRQ_MASK_INDEX * 4;
	localparam logic [31:0] ads [6] = '{ad_sc, ad_pe, ad_es, ad_st, ad_mk, 32'h10};

	// Clock and ready loop
	always #50 sys_clk = ~sys_clk;
	assign hready = hreadyout;

	keypad_wake_unit keypad_wake_unit_inst (.SYS_CLK(sys_clk),
		.RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
		.KEY_INPUT_PINS(pins), .WAIT_MODE(wait_mode),
		.STOP3_MODE(stop3_mode), .KEY_IRQ(key_irq), .WAKE_REQ(wake_req),
		.SYS_IRQ(sys_irq));
	key_switch_model key_switch_model_inst (.level(lvl), .pins(pins));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
			fails++;
		end
	endtask

	// Reference model of controls, arming, flag and sticky status
	logic [7:0] m_hist [$];
	logic [31:0] m_addr;
	logic [2:0] m_exp;
	int m_pe, m_es, m_mode, m_ie, m_mk, m_flag, m_armed, m_st, m_wr;
	int m_now, m_old, m_ev, m_ack, m_ref;
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			m_hist = '{8'h00, 8'h00, 8'h00};
			m_pe = 0;
			m_es = 0;
			m_mode = 0;
			m_ie = 0;
			m_mk = 0;
			m_flag = 0;
			m_armed = 0;
			m_st = 0;
			m_wr = 0;
			m_addr = 32'h0;
		end else begin
			// Synchronised sample and its predecessor, as the unit sees them
			m_now = m_pe & ~(m_hist[1] ^ m_es) & 255;
			m_old = m_pe & ~(m_hist[2] ^ m_es) & 255;
			m_ev = (m_armed && (m_now & ~m_old)) || (m_mode && m_now);
			m_ack = m_wr && m_addr == ad_sc && hwdata[2];
			m_ref = m_ack && m_mode && m_now;
			// Rearm once all enabled pins are deasserted
			if (m_now == 0) begin
				m_armed = 1;
			end else if (m_armed && (m_now & ~m_old)) begin
				m_armed = 0;
			end
			// Event wins over acknowledge
			if (m_ev) begin
				m_flag = 1;
			end else if (m_ack && !m_ref) begin
				m_flag = 0;
			end
			if (m_wr && m_addr == ad_st) begin
				m_st = m_st & ~hwdata[1:0];
			end
			m_st = m_st | (m_ev ? 1 : 0) | (m_ref ? 2 : 0);
			if (m_wr && m_addr == ad_sc) begin
				m_ie = hwdata[1];
				m_mode = hwdata[0];
			end
			if (m_wr && m_addr == ad_pe) begin
				m_pe = hwdata[7:0];
			end
			if (m_wr && m_addr == ad_es) begin
				m_es = hwdata[7:0];
			end
			if (m_wr && m_addr == ad_mk) begin
				m_mk = hwdata[1:0];
			end
			m_wr = hsel && hready && htrans[1] && hwrite;
			m_addr = haddr;
			m_hist.push_front(pins);
			void'(m_hist.pop_back());
		end
	end

	// Settled outputs captured and compared with the model each cycle
	always @(negedge sys_clk) begin
		obs <= {key_irq, wake_req, sys_irq};
		m_exp[2] = m_flag && m_ie;
		m_exp[1] = m_ie && (wait_mode && m_flag || stop3_mode &&
			(m_flag || (m_pe & ~(pins ^ m_es) & 255) != 0));
		m_exp[0] = (m_st & m_mk) != 0;
		if (reset_n === 1'b1) begin
			chk({key_irq, wake_req, sys_irq}, m_exp);
		end
	end

	// One single transfer; ready sampled at the rising edge
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (!hready) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge sys_clk);
		while (!hready) @(posedge sys_clk);
		q = hrdata;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#3000000;
		fails++;
		give_verdict();
	end

	// Pass 0 edge mode, pass 1 edge plus level with inverted polarity
	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		wait_mode = 1'b0;
		stop3_mode = 1'b0;
		lvl = 8'h00;
		rnd = xs(32'hebcf);
		wt(6);
		reset_n <= 1'b1;
		foreach (ads[i]) rd_chk(ads[i], 32'h0);
		for (int p = 0; p < 2; p++) begin
			es = p ? ~rnd[7:0] : rnd[7:0];
			lvl <= ~es;
			xfer(1'b1, ad_es, {24'h0, es});
			xfer(1'b1, ad_pe, 32'h81);
			xfer(1'b1, ad_sc, p | 4);
			rd_chk(ad_es, {24'h0, es});
			lvl <= ~es ^ 8'h02;
			wt(5);
			rd_chk(ad_sc, p);
			lvl <= ~es ^ 8'h03;
			wt(5);
			rd_chk(ad_sc, 8 | p);
			chk(obs, 3'b000);
			xfer(1'b1, ad_sc, p | 2);
			wait_mode <= 1'b1;
			wt(2);
			chk(obs, 3'b110);
			wait_mode <= 1'b0;
			xfer(1'b1, ad_sc, p | 6);
			rd_chk(ad_sc, p ? 11 : 2);
			rd_chk(ad_st, p ? 3 : 1);
			lvl <= ~es ^ 8'h83;
			wt(5);
			rd_chk(ad_sc, p ? 11 : 2);
			lvl <= ~es;
			wt(5);
			xfer(1'b1, ad_sc, p | 6);
			rd_chk(ad_sc, p | 2);
			stop3_mode <= 1'b1;
			lvl <= ~es ^ 8'h01;
			wt(1);
			chk(obs, 3'b010);
			wt(4);
			stop3_mode <= 1'b0;
			xfer(1'b1, ad_mk, 32'h1);
			wt(1);
			chk(obs, 3'b101);
			xfer(1'b1, ad_mk, 32'h0);
			wt(1);
			chk(obs, 3'b100);
			lvl <= ~es;
			wt(5);
			xfer(1'b1, ad_sc, p | 6);
			xfer(1'b1, ad_st, 32'h3);
			rd_chk(ad_st, 32'h0);
		end
		reset_n <= 1'b0;
		wt(2);
		reset_n <= 1'b1;
		rd_chk(ad_pe, 32'h0);
		give_verdict();
	end
endmodule

`default_nettype wire
